//--- hdl/rpp_hist.v
`timescale 1ns/1ps
module rpp_hist #(
  parameter DW    = 34,
  parameter DEPTH = 41,
  parameter DA    = 4,
  parameter DB    = 40
) (
  input  wire          ref_clk,
  input  wire          sys_rst,
  input  wire          ce,
  input  wire          push,
  input  wire [DW-1:0] din,
  output wire [DW-1:0] dly_a,
  output wire [DW-1:0] dly_b
);
  // one entry per 5 ms sample; entry k holds the sample k pushes ago
  reg [DW-1:0] sh_r [0:DEPTH-1];

  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1) begin : g_sh
      always @(posedge ref_clk) begin
        if (sys_rst) begin
          sh_r[i] <= {DW{1'b0}};
        end else if (ce && push) begin
          if (i == 0) begin
            sh_r[i] <= din;
          end else begin
            sh_r[i] <= sh_r[i-1];
          end
        end
      end
    end
  endgenerate

  assign dly_a = sh_r[DA];
  assign dly_b = sh_r[DB];
endmodule // rpp_hist

//--- hdl/rpp_map.vh
`ifndef RPP_MAP_VH
`define RPP_MAP_VH
// Contract
// - seven fundamental magnitudes in, 5 ms refresh
// - active power from currents and LN/LL voltages
// - power to pick-up ratio, 0.01 resolution
// - release below fixed 97 percent of pick-up
// - pick-up setting in 0.01 kW, default 100 kW
// - five modes, default On, globally gated
// - forced status when forcing globally enabled
// - blocking input sampled at each cycle start
// - pick-up unblocked asserts start, starts timing
// - pick-up while blocked asserts blocked only
// - blocking drops start; runs release timing from start, not from trip
// - definite time for operate and reset
// - on/off events, stored edges selectable
// - event time stamp resolution 1 ms
// - resettable start, trip, blocked counters
// - exactly one protection stage
// - circular record of latest twelve operations
// - record fields written on each on-edge
// - expected and remaining time, 5 ms steps
// - setting group change applies while running
// - mode and forcing independent of group

// register byte offsets
`define RPP_A_CTRL     8'h00
`define RPP_A_OPDLY    8'h04
`define RPP_A_RSDLY    8'h08
`define RPP_A_COND     8'h0C
`define RPP_A_RATIO    8'h10
`define RPP_A_EXPT     8'h14
`define RPP_A_REMT     8'h18
`define RPP_A_CNT0     8'h1C
`define RPP_A_CNT1     8'h20
`define RPP_A_CNT2     8'h24
`define RPP_A_CLR      8'h28
`define RPP_A_TIME     8'h2C
`define RPP_A_RSEL     8'h30
`define RPP_A_RTS      8'h34
`define RPP_A_RINFO    8'h38
`define RPP_A_RPRE     8'h3C
`define RPP_A_RFLT     8'h40
`define RPP_A_RPF      8'h44
`define RPP_A_RREM     8'h48
`define RPP_A_PWR      8'h4C
`define RPP_A_U4       8'h50
`define RPP_PSET_PAGE  3'h4

// control register fields
`define RPP_C_MODE     2:0
`define RPP_C_FORCE    4:3
`define RPP_C_LL       5
`define RPP_C_EVON     6
`define RPP_C_EVOFF    7
`define RPP_CTRL_DEF   8'hC0

`define RPP_M_ON       3'h0
`define RPP_M_BLK      3'h1
`define RPP_M_TEST     3'h2
`define RPP_M_TBLK     3'h3
`define RPP_M_OFF      3'h4

`define RPP_F_NORM     2'h0
`define RPP_F_START    2'h1
`define RPP_F_TRIP     2'h2
`define RPP_F_BLK      2'h3

// timing and scaling
`define RPP_CLK_NS      10
`define RPP_TS_RES_NS   1000000
`define RPP_TICK_MS     5
`define RPP_PRE_TRIG_MS 20
`define RPP_PRE_FLT_MS  200
`define RPP_REC_DEPTH   12
`define RPP_REC_LAST    4'hB
`define RPP_PSET_DEF    24'h002710
`define RPP_RST_PCT     7'h61
`define RPP_RATIO_SCALE 7'h64
`define RPP_RATIO_MAX   17'h1E848
`define RPP_INV_SQRT3   16'h93CD
`define RPP_DLY_MAX     19'h57E40
`endif

//--- hdl/rpp_sync.v
`timescale 1ns/1ps
module rpp_sync #(
  parameter W = 1
) (
  input  wire         ref_clk,
  input  wire         sys_rst,
  input  wire         ce,
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
    end else if (ce) begin
      s1_r <= d;
      s2_r <= s1_r;
    end
  end

  assign q = s2_r;
endmodule // rpp_sync

//--- hdl/rpp_top.v
// The AHB-Lite register port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "rpp_map.vh"
module rpp_top #(
  parameter TS_CYC = `RPP_TS_RES_NS / `RPP_CLK_NS
) (
  input  wire        ref_clk,
  input  wire        sys_rst,
  input  wire        ce,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata_r,
  output reg         hreadyout_r,
  output reg         hresp_r,
  input  wire        meas_vld,
  input  wire [15:0] phase_a_current_fundamental,
  input  wire [15:0] phase_b_current_fundamental,
  input  wire [15:0] phase_c_current_fundamental,
  input  wire [15:0] voltage_channel_one_fundamental,
  input  wire [15:0] voltage_channel_two_fundamental,
  input  wire [15:0] voltage_channel_three_fundamental,
  input  wire [15:0] voltage_channel_four_fundamental,
  input  wire        pwr_rev,
  input  wire        blk_pin,
  input  wire [2:0]  set_grp,
  input  wire        mode_set_en,
  input  wire        force_en,
  output reg         start_ind_r,
  output reg         trip_ind_r,
  output reg         blk_ind_r,
  output reg         test_ind_r,
  output reg         evt_vld_r,
  output reg  [2:0]  evt_code_r,
  output reg  [31:0] evt_ts_r
);
  localparam [2:0] S_NORM  = 3'h0;
  localparam [2:0] S_START = 3'h1;
  localparam [2:0] S_TRIP  = 3'h2;
  localparam [2:0] S_BLK   = 3'h3;
  localparam [2:0] S_REL   = 3'h4;
  localparam D_A = `RPP_PRE_TRIG_MS / `RPP_TICK_MS;
  localparam D_B = `RPP_PRE_FLT_MS / `RPP_TICK_MS;

  reg  [7:0]  ctrl_r;
  reg  [18:0] op_dly_r;
  reg  [18:0] rs_dly_r;
  reg  [23:0] pset_r [0:7];
  reg  [33:0] measured_active_power_r;
  reg         blk_smp_r;
  reg         tk_r;
  reg         pick_r;
  reg  [2:0]  st_r;
  reg  [18:0] op_cnt_r;
  reg  [18:0] rs_cnt_r;
  reg  [31:0] ts_r;
  reg  [31:0] ts_pre_r;
  reg  [5:0]  pend_r;
  reg  [2:0]  rpend_r;
  reg  [15:0] cnt_r [0:2];
  reg         wr_r;
  reg  [7:0]  wa_r;
  reg  [3:0]  rec_sel_r;
  reg  [3:0]  rec_wp_r;
  reg  [3:0]  rec_n_r;
  reg  [31:0] rec_ts [0:`RPP_REC_DEPTH-1];
  reg  [2:0]  rec_ev [0:`RPP_REC_DEPTH-1];
  reg  [2:0]  rec_grp [0:`RPP_REC_DEPTH-1];
  reg  [33:0] rec_pre [0:`RPP_REC_DEPTH-1];
  reg  [33:0] rec_flt [0:`RPP_REC_DEPTH-1];
  reg  [33:0] rec_pf [0:`RPP_REC_DEPTH-1];
  reg  [18:0] rec_rem [0:`RPP_REC_DEPTH-1];
  reg         dv_busy_r;
  reg  [5:0]  dv_cnt_r;
  reg  [40:0] dv_num_r;
  reg  [23:0] dv_den_r;
  reg  [23:0] dv_rem_r;
  reg  [16:0] dv_q_r;
  reg  [16:0] ratio_r;
  reg  [2:0]  ind_w;
  reg  [2:0]  ev_idx;
  reg  [1:0]  rk_idx;
  reg  [31:0] rd_w;
  integer     i;

  wire        blk_s;
  wire [33:0] pre_trig_w;
  wire [33:0] pre_flt_w;

  rpp_sync #(.W(1)) u_sync (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .d       (blk_pin),
    .q       (blk_s)
  );

  // power history, pushed once per 5 ms measurement
  rpp_hist #(.DW(34), .DEPTH(D_B + 1), .DA(D_A), .DB(D_B)) u_hist (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .push    (tk_r),
    .din     (measured_active_power_r),
    .dly_a   (pre_trig_w),
    .dly_b   (pre_flt_w)
  );

  // bus decode, zero wait states
  wire ap = hsel & htrans[1] & hready;
  wire we = wr_r;

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      wr_r        <= 1'b0;
      wa_r        <= 8'h00;
      hrdata_r    <= 32'h00000000;
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
    end else if (ce) begin
      wr_r <= ap & hwrite;
      wa_r <= haddr[7:0];
      if (ap && !hwrite) begin
        hrdata_r <= rd_w;
      end
    end
  end

  // static settings, untouched by group changes
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl_r    <= `RPP_CTRL_DEF;
      op_dly_r  <= 19'h00000;
      rs_dly_r  <= 19'h00000;
      rec_sel_r <= 4'h0;
    end else if (ce && we) begin
      case (wa_r)
        `RPP_A_CTRL:  ctrl_r <= hwdata[7:0];
        `RPP_A_OPDLY: op_dly_r <= (hwdata[18:0] > `RPP_DLY_MAX) ? `RPP_DLY_MAX : hwdata[18:0];
        `RPP_A_RSDLY: rs_dly_r <= (hwdata[18:0] > `RPP_DLY_MAX) ? `RPP_DLY_MAX : hwdata[18:0];
        `RPP_A_RSEL:  rec_sel_r <= (hwdata[3:0] > `RPP_REC_LAST) ? `RPP_REC_LAST : hwdata[3:0];
        default: ;
      endcase
    end
  end

  // one pick-up setting per group, in 0.01 kW steps
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_pset
      always @(posedge ref_clk) begin
        if (sys_rst) begin
          pset_r[g] <= `RPP_PSET_DEF;
        end else if (ce && we && wa_r[7:5] == `RPP_PSET_PAGE && wa_r[4:2] == g) begin
          pset_r[g] <= hwdata[23:0];
        end
      end
    end
  endgenerate

  wire [23:0] pset_w = pset_r[set_grp];
  wire [2:0]  mode_w = mode_set_en ? ctrl_r[`RPP_C_MODE] : `RPP_M_ON;
  wire        off_w  = (mode_w == `RPP_M_OFF);
  wire        mblk_w = (mode_w == `RPP_M_BLK) || (mode_w == `RPP_M_TBLK);
  wire        test_w = (mode_w == `RPP_M_TEST) || (mode_w == `RPP_M_TBLK);

  // three-phase active power, reverse flow only
  wire [31:0] p_a   = phase_a_current_fundamental * voltage_channel_one_fundamental;
  wire [31:0] p_b   = phase_b_current_fundamental * voltage_channel_two_fundamental;
  wire [31:0] p_c   = phase_c_current_fundamental * voltage_channel_three_fundamental;
  wire [33:0] p_sum = {2'h0, p_a} + {2'h0, p_b} + {2'h0, p_c};
  wire [49:0] p_ll  = p_sum * `RPP_INV_SQRT3;
  wire [33:0] p_new = !pwr_rev ? 34'h0 : (ctrl_r[`RPP_C_LL] ? p_ll[49:16] : p_sum);

  // pick-up with built-in hysteresis
  wire [40:0] pm100  = measured_active_power_r * `RPP_RATIO_SCALE;
  wire [40:0] thr100 = {17'h00000, pset_w} * `RPP_RATIO_SCALE;
  wire [40:0] thr97  = {17'h00000, pset_w} * `RPP_RST_PCT;
  wire        pick_w = pick_r ? (pm100 >= thr97) : (pm100 >= thr100);
  wire        blk_w  = blk_smp_r | mblk_w;

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      measured_active_power_r <= 34'h0;
      blk_smp_r <= 1'b0;
      tk_r      <= 1'b0;
    end else if (ce) begin
      tk_r <= meas_vld;
      if (meas_vld) begin
        measured_active_power_r <= p_new;
        blk_smp_r <= blk_s;
      end
    end
  end

  // single stage definite-time state machine
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      st_r     <= S_NORM;
      pick_r   <= 1'b0;
      op_cnt_r <= 19'h00000;
      rs_cnt_r <= 19'h00000;
    end else if (ce && tk_r) begin
      pick_r <= pick_w & ~off_w;
      if (off_w) begin
        st_r     <= S_NORM;
        op_cnt_r <= 19'h00000;
        rs_cnt_r <= 19'h00000;
      end else begin
        case (st_r)
          S_NORM: begin
            if (pick_w) begin
              st_r     <= blk_w ? S_BLK : S_START;
              op_cnt_r <= 19'h00000;
            end
          end
          S_START: begin
            if (!pick_w || blk_w) begin
              st_r     <= S_REL;
              rs_cnt_r <= 19'h00000;
            end else if (op_cnt_r + 19'h00001 >= op_dly_r) begin
              st_r <= S_TRIP;
            end else begin
              op_cnt_r <= op_cnt_r + 19'h00001;
            end
          end
          S_TRIP: begin
            if (!pick_w || blk_w) begin
              st_r     <= S_NORM;
              op_cnt_r <= 19'h00000;
            end
          end
          S_BLK: begin
            if (!pick_w) begin
              st_r <= S_NORM;
            end else if (!blk_w) begin
              st_r     <= S_START;
              op_cnt_r <= 19'h00000;
            end
          end
          S_REL: begin
            if (pick_w && !blk_w) begin
              st_r <= S_START;
            end else if (rs_cnt_r + 19'h00001 >= rs_dly_r) begin
              st_r     <= S_NORM;
              op_cnt_r <= 19'h00000;
            end else begin
              rs_cnt_r <= rs_cnt_r + 19'h00001;
            end
          end
          default: st_r <= S_NORM;
        endcase
      end
    end
  end

  wire [18:0] rem_w = (st_r == S_START) ? (op_dly_r - op_cnt_r) : 19'h00000;

  // indications: {blocked, trip, start}
  always @* begin
    ind_w = 3'h0;
    if (!off_w) begin
      if (force_en) begin
        case (ctrl_r[`RPP_C_FORCE])
          `RPP_F_START: ind_w = 3'h1;
          `RPP_F_TRIP:  ind_w = 3'h3;
          `RPP_F_BLK:   ind_w = 3'h4;
          default:      ind_w = 3'h0;
        endcase
      end else begin
        ind_w = {st_r == S_BLK, st_r == S_TRIP, (st_r == S_START) || (st_r == S_TRIP)};
      end
    end
  end

  wire [2:0] ind_q = {blk_ind_r, trip_ind_r, start_ind_r};
  wire [2:0] on_e  = ind_w & ~ind_q;
  wire [2:0] off_e = ~ind_w & ind_q;
  wire       eon   = ctrl_r[`RPP_C_EVON];
  wire       eoff  = ctrl_r[`RPP_C_EVOFF];
  wire [5:0] ev_new = {off_e[2] & eoff, on_e[2] & eon, off_e[1] & eoff,
                       on_e[1] & eon, off_e[0] & eoff, on_e[0] & eon};

  always @* begin
    ev_idx = 3'h0;
    for (i = 5; i >= 0; i = i - 1) begin
      if (pend_r[i]) begin
        ev_idx = i[2:0];
      end
    end
    rk_idx = rpend_r[0] ? 2'h0 : (rpend_r[1] ? 2'h1 : 2'h2);
  end

  wire       ev_any = |pend_r;
  wire [5:0] ev_clr = ev_any ? (6'h01 << ev_idx) : 6'h00;
  wire       rc_any = |rpend_r;
  wire [2:0] rc_clr = rc_any ? (3'h1 << rk_idx) : 3'h0;

  // events leave one per cycle; a new edge is never lost to the clear
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      start_ind_r <= 1'b0;
      trip_ind_r  <= 1'b0;
      blk_ind_r   <= 1'b0;
      test_ind_r  <= 1'b0;
      pend_r      <= 6'h00;
      rpend_r     <= 3'h0;
      evt_vld_r   <= 1'b0;
      evt_code_r  <= 3'h0;
      evt_ts_r    <= 32'h00000000;
    end else if (ce) begin
      {blk_ind_r, trip_ind_r, start_ind_r} <= ind_w;
      test_ind_r <= test_w;
      pend_r     <= (pend_r & ~ev_clr) | ev_new;
      rpend_r    <= (rpend_r & ~rc_clr) | on_e;
      evt_vld_r  <= ev_any;
      evt_code_r <= {ev_idx[2:1] + 2'h1, ~ev_idx[0]};
      evt_ts_r   <= ts_r;
    end
  end

  // millisecond time base, loadable by software
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      ts_r     <= 32'h00000000;
      ts_pre_r <= 32'h00000000;
    end else if (ce) begin
      if (ts_pre_r == TS_CYC - 1) begin
        ts_pre_r <= 32'h00000000;
      end else begin
        ts_pre_r <= ts_pre_r + 32'h00000001;
      end
      if (we && wa_r == `RPP_A_TIME) begin
        ts_r <= hwdata;
      end else if (ts_pre_r == TS_CYC - 1) begin
        ts_r <= ts_r + 32'h00000001;
      end
    end
  end

  // cumulative counters, an increment beats a clear
  genvar k;
  generate
    for (k = 0; k < 3; k = k + 1) begin : g_cnt
      always @(posedge ref_clk) begin
        if (sys_rst) begin
          cnt_r[k] <= 16'h0000;
        end else if (ce) begin
          if (on_e[k]) begin
            cnt_r[k] <= cnt_r[k] + 16'h0001;
          end else if (we && wa_r == `RPP_A_CLR && hwdata[k]) begin
            cnt_r[k] <= 16'h0000;
          end
        end
      end
    end
  endgenerate

  // circular operation record
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      rec_wp_r <= 4'h0;
      rec_n_r  <= 4'h0;
    end else if (ce && rc_any) begin
      rec_ts[rec_wp_r]  <= ts_r;
      rec_ev[rec_wp_r]  <= {rk_idx + 2'h1, 1'b1};
      rec_grp[rec_wp_r] <= set_grp;
      rec_pre[rec_wp_r] <= pre_trig_w;
      rec_flt[rec_wp_r] <= measured_active_power_r;
      rec_pf[rec_wp_r]  <= pre_flt_w;
      rec_rem[rec_wp_r] <= rem_w;
      rec_wp_r <= (rec_wp_r == `RPP_REC_LAST) ? 4'h0 : rec_wp_r + 4'h1;
      if (rec_n_r != `RPP_REC_LAST + 4'h1) begin
        rec_n_r <= rec_n_r + 4'h1;
      end
    end
  end

  // ratio Pm/Pset in hundredths, serial restoring division
  wire [40:0] sat_lim = {17'h00000, pset_w} * `RPP_RATIO_MAX;
  wire [24:0] dv_try  = {dv_rem_r, dv_num_r[40]};
  wire        dv_ge   = dv_try >= {1'b0, dv_den_r};
  wire [24:0] dv_sub  = dv_try - {1'b0, dv_den_r};

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      dv_busy_r <= 1'b0;
      dv_cnt_r  <= 6'h00;
      dv_num_r  <= 41'h0;
      dv_den_r  <= 24'h000000;
      dv_rem_r  <= 24'h000000;
      dv_q_r    <= 17'h00000;
      ratio_r   <= 17'h00000;
    end else if (ce) begin
      if (tk_r) begin
        if (pset_w == 24'h000000 || pm100 >= sat_lim) begin
          ratio_r   <= `RPP_RATIO_MAX;
          dv_busy_r <= 1'b0;
        end else begin
          dv_busy_r <= 1'b1;
          dv_cnt_r  <= 6'h29;
          dv_num_r  <= pm100;
          dv_den_r  <= pset_w;
          dv_rem_r  <= 24'h000000;
          dv_q_r    <= 17'h00000;
        end
      end else if (dv_busy_r) begin
        dv_num_r <= {dv_num_r[39:0], 1'b0};
        dv_rem_r <= dv_ge ? dv_sub[23:0] : dv_try[23:0];
        dv_q_r   <= {dv_q_r[15:0], dv_ge};
        dv_cnt_r <= dv_cnt_r - 6'h01;
        if (dv_cnt_r == 6'h01) begin
          dv_busy_r <= 1'b0;
          ratio_r   <= {dv_q_r[15:0], dv_ge};
        end
      end
    end
  end

  // read mux, sampled in the address phase
  wire [3:0] rs = rec_sel_r;
  always @* begin
    rd_w = 32'h00000000;
    if (haddr[7:5] == `RPP_PSET_PAGE) begin
      rd_w = {8'h00, pset_r[haddr[4:2]]};
    end else begin
      case (haddr[7:0])
        `RPP_A_CTRL:  rd_w = {24'h000000, ctrl_r};
        `RPP_A_OPDLY: rd_w = {13'h0000, op_dly_r};
        `RPP_A_RSDLY: rd_w = {13'h0000, rs_dly_r};
        `RPP_A_COND:  rd_w = {26'h0000000, test_w, mode_w, ind_w[2] ? `RPP_F_BLK :
                              ind_w[1] ? `RPP_F_TRIP : ind_w[0] ? `RPP_F_START : `RPP_F_NORM};
        `RPP_A_RATIO: rd_w = {15'h0000, ratio_r};
        `RPP_A_EXPT:  rd_w = {13'h0000, op_dly_r};
        `RPP_A_REMT:  rd_w = {13'h0000, rem_w};
        `RPP_A_CNT0:  rd_w = {16'h0000, cnt_r[0]};
        `RPP_A_CNT1:  rd_w = {16'h0000, cnt_r[1]};
        `RPP_A_CNT2:  rd_w = {16'h0000, cnt_r[2]};
        `RPP_A_TIME:  rd_w = ts_r;
        `RPP_A_RSEL:  rd_w = {28'h0000000, rec_sel_r};
        `RPP_A_RTS:   rd_w = rec_ts[rs];
        `RPP_A_RINFO: rd_w = {18'h00000, rec_n_r, rec_wp_r, rec_grp[rs], rec_ev[rs]};
        `RPP_A_RPRE:  rd_w = rec_pre[rs][31:0];
        `RPP_A_RFLT:  rd_w = rec_flt[rs][31:0];
        `RPP_A_RPF:   rd_w = rec_pf[rs][31:0];
        `RPP_A_RREM:  rd_w = {13'h0000, rec_rem[rs]};
        `RPP_A_PWR:   rd_w = measured_active_power_r[31:0];
        `RPP_A_U4:    rd_w = {16'h0000, voltage_channel_four_fundamental};
        default:      rd_w = 32'h00000000;
      endcase
    end
  end
endmodule // rpp_top

//--- tb/reverse_power_protection_stage_tb.sv
`timescale 1ns/1ps
module reverse_power_protection_stage_tb;
  reg         ref_clk, sys_rst, hsel, hwrite, meas_vld, blk_pin, mset, fen;
  reg  [1:0]  htrans;
  reg  [2:0]  sg;
  reg  [31:0] haddr, hwdata, rd;
  reg  [15:0] cur, vlt;
  wire [31:0] hrdata, ets;
  wire        hrdy, hresp, st, tr, bk, tst, ev;
  wire [2:0]  ec;
  integer     n_mismatch, checks_done, cyc, i;

  rpp_top #(.TS_CYC(10)) DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .ce(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy),
    .hrdata_r(hrdata), .hreadyout_r(hrdy), .hresp_r(hresp), .meas_vld(meas_vld),
    .phase_a_current_fundamental(cur), .phase_b_current_fundamental(cur),
    .phase_c_current_fundamental(cur), .voltage_channel_one_fundamental(vlt),
    .voltage_channel_two_fundamental(vlt), .voltage_channel_three_fundamental(vlt),
    .voltage_channel_four_fundamental(16'h1234), .pwr_rev(1'b1), .blk_pin(blk_pin), .set_grp(sg),
    .mode_set_en(mset), .force_en(fen), .start_ind_r(st), .trip_ind_r(tr), .blk_ind_r(bk),
    .test_ind_r(tst), .evt_vld_r(ev), .evt_code_r(ec), .evt_ts_r(ets));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task report_and_stop;
    begin
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask

  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      report_and_stop;
    end
  end

  task chk(input [31:0] g, input [31:0] e);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask

  // indications as {start, trip, blocked}
  task chki(input [2:0] e);
    begin
      chk({29'h0, st, tr, bk}, {29'h0, e});
    end
  endtask

  task bus(input w, input [7:0] a, input [31:0] d);
    begin
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      @(posedge ref_clk);
      while (hrdy !== 1'b1) @(posedge ref_clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge ref_clk);
      while (hrdy !== 1'b1) @(posedge ref_clk);
      rd = hrdata;
    end
  endtask

  task wr(input [7:0] a, input [31:0] d);
    begin
      bus(1'b1, a, d);
    end
  endtask

  task rdc(input [7:0] a, input [31:0] e);
    begin
      bus(1'b0, a, 32'h0);
      chk(rd, e);
    end
  endtask

  // blocking is set early so the synchroniser has settled before the sample
  task tick(input [15:0] c, input [15:0] v, input b);
    begin
      cur <= c;
      vlt <= v;
      blk_pin <= b;
      repeat (5) @(posedge ref_clk);
      meas_vld <= 1'b1;
      @(posedge ref_clk);
      meas_vld <= 1'b0;
      repeat (60) @(posedge ref_clk);
    end
  endtask

  initial begin
    sys_rst = 1'b1;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    meas_vld = 1'b0;
    blk_pin = 1'b0;
    cur = 16'h0;
    vlt = 16'h0;
    sg = 3'h0;
    mset = 1'b0;
    fen = 1'b0;
    n_mismatch = 0;
    checks_done = 0;
    cyc = 0;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    rdc(8'h00, 32'hC0);
    rdc(8'h80, 32'h2710);
    rdc(8'hFC, 32'h0);
    wr(8'h80, 32'h7530);
    wr(8'h84, 32'hFFFFFF);
    wr(8'h04, 32'h3);
    rdc(8'h14, 32'h3);
    tick(16'd100, 16'd100, 1'b0);
    chki(3'h4);
    rdc(8'h10, 32'd100);
    rdc(8'h4C, 32'd30000);
    rdc(8'h50, 32'h1234);
    tick(16'd100, 16'd98, 1'b0);
    chki(3'h4);
    tick(16'd100, 16'd98, 1'b0);
    chki(3'h4);
    tick(16'd100, 16'd98, 1'b0);
    chki(3'h6);
    rdc(8'h1C, 32'h1);
    rdc(8'h20, 32'h1);
    tick(16'd100, 16'd96, 1'b0);
    chki(3'h0);
    tick(16'd100, 16'd100, 1'b1);
    chki(3'h1);
    rdc(8'h24, 32'h1);
    wr(8'h30, 32'h2);
    rdc(8'h38, 32'hCC7);
    rdc(8'h3C, 32'd29400);
    rdc(8'h40, 32'd30000);
    tick(16'd0, 16'd0, 1'b0);
    tick(16'd100, 16'd100, 1'b0);
    tick(16'd100, 16'd100, 1'b1);
    chk({31'h0, st}, 32'h0);
    tick(16'd0, 16'd0, 1'b0);
    tick(16'd100, 16'd100, 1'b0);
    sg <= 3'h1;
    tick(16'd100, 16'd100, 1'b0);
    chk({31'h0, st}, 32'h0);
    tick(16'd0, 16'd0, 1'b0);
    wr(8'h28, 32'h7);
    rdc(8'h1C, 32'h0);
    rdc(8'h24, 32'h0);
    wr(8'h2C, 32'h100);
    rdc(8'h2C, 32'h100);
    wr(8'h2C, 32'h100);
    // thirty-two cycles after the load hold exactly three 1 ms steps
    repeat (32) @(posedge ref_clk);
    chk(ets, 32'h103);
    mset <= 1'b1;
    for (i = 0; i < 5; i = i + 1) begin
      wr(8'h00, {24'h0, 5'h18, i[2:0]});
      sg <= i[2:0];
      rdc(8'h0C, {26'h0, (i == 2 || i == 3), i[2:0], 2'h0});
      chk({31'h0, tst}, {31'h0, (i == 2 || i == 3)});
    end
    tick(16'd100, 16'd100, 1'b0);
    chki(3'h0);
    wr(8'h00, 32'hC0);
    tick(16'd0, 16'd0, 1'b0);
    fen <= 1'b1;
    for (i = 0; i < 4; i = i + 1) begin
      wr(8'h00, {24'h0, 3'h6, i[1:0], 3'h0});
      repeat (5) @(posedge ref_clk);
      chki(i == 0 ? 3'h0 : i == 1 ? 3'h4 : i == 2 ? 3'h6 : 3'h1);
    end
    fen <= 1'b0;
    wr(8'h00, 32'hC0);
    repeat (5) @(posedge ref_clk);
    report_and_stop;
  end
endmodule // reverse_power_protection_stage_tb

//--- tb/rpp_assertions.sv
`timescale 1ns/1ps
module rpp_chk #(
  parameter TS_CYC = 10
) (
  input wire        ref_clk,
  input wire        sys_rst,
  input wire        ce,
  input wire        hsel,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire [31:0] hrdata_r,
  input wire        hreadyout_r,
  input wire        hresp_r,
  input wire        meas_vld,
  input wire        force_en,
  input wire        start_ind_r,
  input wire        trip_ind_r,
  input wire        blk_ind_r,
  input wire        evt_vld_r,
  input wire [2:0]  evt_code_r
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  ready_always_a: assert property (hreadyout_r) else $error("hreadyout low");
  resp_okay_a: assert property (!hresp_r) else $error("hresp not okay");
  rdata_hold_a: assert property (!$stable(hrdata_r) |-> $past(hsel && htrans[1] && !hwrite && hready && ce))
    else $error("read data changed without read");
  trip_needs_start_a: assert property (trip_ind_r |-> start_ind_r) else $error("trip without start");
  start_after_tick_a: assert property (($rose(start_ind_r) && !force_en && !$past(force_en, 4)) |->
    $past(meas_vld, 3)) else $error("start not three edges after tick");
  start_evt_a: assert property ((evt_vld_r && evt_code_r == 3'h3) |-> start_ind_r)
    else $error("start on event without start");
  trip_evt_a: assert property ((evt_vld_r && evt_code_r == 3'h5) |-> trip_ind_r)
    else $error("trip on event without trip");
  blk_excl_a: assert property (blk_ind_r |-> !start_ind_r) else $error("blocked with start");
  evt_code_a: assert property (evt_vld_r |-> (evt_code_r >= 3'h2)) else $error("illegal event code");
endmodule // rpp_chk

bind rpp_top rpp_chk #(.TS_CYC(TS_CYC)) u_chk (.ref_clk, .sys_rst, .ce, .hsel, .htrans, .hwrite, .hready,
  .hrdata_r, .hreadyout_r, .hresp_r, .meas_vld, .force_en, .start_ind_r, .trip_ind_r, .blk_ind_r,
  .evt_vld_r, .evt_code_r);
